// [vga_path_consts.vh]
`ifndef VGA_PATH_CONSTS_VH
`define VGA_PATH_CONSTS_VH

// ----------------------------------------------------------------------------
// Register window and offsets
// ----------------------------------------------------------------------------
`define WIN_BASE          16'h8100
`define WIN_SIZE          16'h0200
`define OFS_WRITE_CTRL    16'h8140
`define OFS_READ_CTRL     16'h8144
`define OFS_BASE_OFFSET   16'h8210
`define OFS_LATCH         16'h8214

// ----------------------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------------------
`define WRITE_CTRL_MASK   32'h0f1fffff
`define READ_CTRL_MASK    32'h0003ffff
`define BASE_OFFSET_MASK  32'h00003f3f
`define WRITE_CTRL_RESET  32'h00000000
`define READ_CTRL_RESET   32'h00000000
`define BASE_OFFSET_RESET 32'h00000000
`define LATCH_RESET       32'h00000000

// ----------------------------------------------------------------------------
// Write path control fields
// ----------------------------------------------------------------------------
`define WR_PLANE_EN_HI    27
`define WR_PLANE_EN_LO    24
`define WR_MODE3_BIT      20
`define WR_MODE2_BIT      19
`define WR_ROT_HI         18
`define WR_ROT_LO         16
`define WR_SRE_HI         15
`define WR_SRE_LO         12
`define WR_SRV_HI         11
`define WR_SRV_LO         8
`define WR_MASK_HI        7
`define WR_MASK_LO        0

// ----------------------------------------------------------------------------
// Read path control fields
// ----------------------------------------------------------------------------
`define RD_PLANE_HI       17
`define RD_PLANE_LO       16
`define RD_FORCE15_BIT    15
`define RD_PACKED4_BIT    14
`define RD_CHAIN4_BIT     13
`define RD_PAGE_BIT       12
`define RD_ODD_EVEN_BIT   11
`define RD_WCHAIN2_BIT    10
`define RD_RCHAIN2_BIT    9
`define RD_MODE_BIT       8
`define RD_CMP_MASK_HI    7
`define RD_CMP_MASK_LO    4
`define RD_CMP_VAL_HI     3
`define RD_CMP_VAL_LO     0

// ----------------------------------------------------------------------------
// Base offset fields
// ----------------------------------------------------------------------------
`define BASE_RD_HI        13
`define BASE_RD_LO        8
`define BASE_WR_HI        5
`define BASE_WR_LO        0

// ----------------------------------------------------------------------------
// Memory side widths
// ----------------------------------------------------------------------------
`define MEM_AW            20
`define BASE_SHIFT        14

`endif

// [vga_write_datapath.v]
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Per-plane write data builder: rotation, set/reset, write modes, bit mask.
// ----------------------------------------------------------------------------
module vga_write_datapath (
   // Processor byte and latched data
   input  wire [7:0]  i_cpu_byte,
   input  wire [31:0] i_latch,
   // Write controls
   input  wire [2:0]  i_rotate_count,
   input  wire [3:0]  i_set_reset_enable,
   input  wire [3:0]  i_set_reset_value,
   input  wire [7:0]  i_bit_mask,
   input  wire        i_mode_two,
   input  wire        i_mode_three,
   // Result, one byte per plane
   output wire [31:0] o_plane_data
);

   wire [15:0] dbl_w;
   wire [15:0] shifted_w;
   wire [7:0]  rotated_w;
   wire [7:0]  mode3_mask_w;

   assign dbl_w     = {i_cpu_byte, i_cpu_byte};
   assign shifted_w = dbl_w >> i_rotate_count;
   assign rotated_w = shifted_w[7:0];

   // Mode 3 narrows the bit mask by the rotated byte.
   assign mode3_mask_w = i_bit_mask & rotated_w;

   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_plane
         reg [7:0] val_r;
         reg [7:0] mask_r;
         always @* begin
            if (i_mode_three) begin
               val_r  = {8{i_set_reset_value[p]}};
               mask_r = mode3_mask_w;
            end else if (i_mode_two) begin
               val_r  = {8{i_cpu_byte[p]}};
               mask_r = i_bit_mask;
            end else begin
               val_r  = i_set_reset_enable[p] ? {8{i_set_reset_value[p]}}
                                              : rotated_w;
               mask_r = i_bit_mask;
            end
         end
         // Mask bit high takes new data, low keeps the latched byte.
         assign o_plane_data[8*p+7:8*p] = (val_r & mask_r)
                                        | (i_latch[8*p+7:8*p] & ~mask_r);
      end
   endgenerate

endmodule // vga_write_datapath

// [vga_planar_memory_path.v]
`timescale 1ns/100ps
`include "vga_path_consts.vh"

module vga_planar_memory_path (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_nrst,
   // Register access, offsets from the graphics register base
   input  wire        i_reg_req,
   input  wire        i_reg_we,
   input  wire [15:0] i_reg_addr,
   input  wire [31:0] i_reg_wdata,
   output reg  [31:0] o_reg_rdata,
   output reg         o_reg_ack,
   // VGA frame buffer access from the processor
   input  wire        i_vga_req,
   input  wire        i_vga_we,
   input  wire [15:0] i_vga_addr,
   input  wire [7:0]  i_vga_wdata,
   output reg  [7:0]  o_vga_rdata,
   output reg         o_vga_ack,
   // Graphics memory, one dword holds the four planes
   output reg         o_mem_req,
   output reg         o_mem_we,
   output reg  [19:0] o_mem_addr,
   output reg  [3:0]  o_mem_plane_en,
   output reg  [31:0] o_mem_wdata,
   input  wire [31:0] i_mem_rdata,
   input  wire        i_mem_ack
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_MEM  = 1'b1;

   reg         state_q;
   reg  [31:0] write_ctrl_q;
   reg  [31:0] read_ctrl_q;
   reg  [31:0] base_offset_q;
   reg  [31:0] latch_q;
   reg  [1:0]  rd_plane_q;
   reg         rd_is_read_q;

   // -------------------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------------------
   wire [3:0] plane_write_enable;
   wire       write_mode_three_select;
   wire       write_mode_two_select;
   wire [2:0] rotate_count;
   wire [3:0] set_reset_enable;
   wire [3:0] set_reset_value;
   wire [7:0] latch_select_mask;
   wire [1:0] read_plane_select;
   wire       force_addr15_low;
   wire       packed_chain_four;
   wire       chain_four_mode;
   wire       page_bit;
   wire       odd_even_chaining;
   wire       write_chain_two;
   wire       read_chain_two;
   wire       read_mode_select;
   wire [3:0] compare_plane_mask;
   wire [3:0] compare_values;
   wire [5:0] read_base;
   wire [5:0] write_base;

   assign plane_write_enable      = write_ctrl_q[`WR_PLANE_EN_HI:`WR_PLANE_EN_LO];
   assign write_mode_three_select = write_ctrl_q[`WR_MODE3_BIT];
   assign write_mode_two_select   = write_ctrl_q[`WR_MODE2_BIT];
   assign rotate_count            = write_ctrl_q[`WR_ROT_HI:`WR_ROT_LO];
   assign set_reset_enable        = write_ctrl_q[`WR_SRE_HI:`WR_SRE_LO];
   assign set_reset_value         = write_ctrl_q[`WR_SRV_HI:`WR_SRV_LO];
   assign latch_select_mask       = write_ctrl_q[`WR_MASK_HI:`WR_MASK_LO];
   assign read_plane_select       = read_ctrl_q[`RD_PLANE_HI:`RD_PLANE_LO];
   assign force_addr15_low        = read_ctrl_q[`RD_FORCE15_BIT];
   assign packed_chain_four       = read_ctrl_q[`RD_PACKED4_BIT];
   assign chain_four_mode         = read_ctrl_q[`RD_CHAIN4_BIT];
   assign page_bit                = read_ctrl_q[`RD_PAGE_BIT];
   assign odd_even_chaining       = read_ctrl_q[`RD_ODD_EVEN_BIT];
   assign write_chain_two         = read_ctrl_q[`RD_WCHAIN2_BIT];
   assign read_chain_two          = read_ctrl_q[`RD_RCHAIN2_BIT];
   assign read_mode_select        = read_ctrl_q[`RD_MODE_BIT];
   assign compare_plane_mask      = read_ctrl_q[`RD_CMP_MASK_HI:`RD_CMP_MASK_LO];
   assign compare_values          = read_ctrl_q[`RD_CMP_VAL_HI:`RD_CMP_VAL_LO];
   assign read_base               = base_offset_q[`BASE_RD_HI:`BASE_RD_LO];
   assign write_base              = base_offset_q[`BASE_WR_HI:`BASE_WR_LO];

   // -------------------------------------------------------------------------
   // Register decode
   // -------------------------------------------------------------------------
   // Offsets outside the window are not this block's and get no answer.
   function in_window;
      input [15:0] a;
      begin
         in_window = (a >= `WIN_BASE) && (a < (`WIN_BASE + `WIN_SIZE));
      end
   endfunction

   function [31:0] reg_value;
      input [15:0] a;
      begin
         case (a)
            `OFS_WRITE_CTRL:  reg_value = write_ctrl_q;
            `OFS_READ_CTRL:   reg_value = read_ctrl_q;
            `OFS_BASE_OFFSET: reg_value = base_offset_q;
            `OFS_LATCH:       reg_value = latch_q;
            default:          reg_value = 32'h00000000;
         endcase
      end
   endfunction

   wire reg_hit;
   wire reg_wr;

   assign reg_hit = i_reg_req && in_window(i_reg_addr);
   assign reg_wr  = reg_hit && i_reg_we;

   // -------------------------------------------------------------------------
   // Address mapping
   // -------------------------------------------------------------------------
   wire        wr_chain2;
   wire        rd_chain2;
   reg  [15:0] vga_addr;
   wire [15:0] mapped_addr;
   wire [5:0]  sel_base;
   wire [19:0] mem_addr_d;

   assign wr_chain2 = write_chain_two && !chain_four_mode;
   assign rd_chain2 = read_chain_two && !chain_four_mode;

   always @* begin
      vga_addr = i_vga_addr;
      if (chain_four_mode && packed_chain_four) begin
         vga_addr = {2'b00, i_vga_addr[15:2]};
      end
      if (odd_even_chaining) begin
         vga_addr[0] = page_bit;
      end
   end

   assign mapped_addr = {vga_addr[15] & ~force_addr15_low, vga_addr[14:0]};
   assign sel_base    = i_vga_we ? write_base : read_base;
   assign mem_addr_d  = {sel_base, 14'h0000} + {4'h0, mapped_addr};

   // -------------------------------------------------------------------------
   // Plane selection
   // -------------------------------------------------------------------------
   function [3:0] plane_onehot;
      input [1:0] n;
      begin
         plane_onehot = 4'h1 << n;
      end
   endfunction

   reg [3:0] wr_planes_d;
   reg [1:0] rd_plane_d;

   always @* begin
      if (chain_four_mode) begin
         wr_planes_d = plane_write_enable & plane_onehot(i_vga_addr[1:0]);
      end else if (wr_chain2) begin
         wr_planes_d = plane_write_enable
                     & (i_vga_addr[0] ? 4'ha : 4'h5);
      end else begin
         wr_planes_d = plane_write_enable;
      end
   end

   always @* begin
      if (chain_four_mode) begin
         rd_plane_d = i_vga_addr[1:0];
      end else if (rd_chain2) begin
         rd_plane_d = {read_plane_select[1], i_vga_addr[0]};
      end else begin
         rd_plane_d = read_plane_select;
      end
   end

   // -------------------------------------------------------------------------
   // Write data
   // -------------------------------------------------------------------------
   wire [31:0] plane_data;

   vga_write_datapath u_write_datapath (
      .i_cpu_byte         (i_vga_wdata),
      .i_latch            (latch_q),
      .i_rotate_count     (rotate_count),
      .i_set_reset_enable (set_reset_enable),
      .i_set_reset_value  (set_reset_value),
      .i_bit_mask         (latch_select_mask),
      .i_mode_two         (write_mode_two_select),
      .i_mode_three       (write_mode_three_select),
      .o_plane_data       (plane_data)
   );

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   reg [7:0] plane_byte;
   reg [7:0] cmp_byte;
   integer   b;

   always @* begin
      plane_byte = i_mem_rdata[8*rd_plane_q +: 8];
      cmp_byte   = 8'h00;
      for (b = 0; b < 8; b = b + 1) begin
         cmp_byte[b] = ~|(compare_plane_mask
                        & ({i_mem_rdata[24+b], i_mem_rdata[16+b],
                            i_mem_rdata[8+b], i_mem_rdata[b]}
                           ^ compare_values));
      end
   end

   // -------------------------------------------------------------------------
   // Access sequencer
   // -------------------------------------------------------------------------
   // One VGA access at a time; a new request is taken only when idle, so
   // the processor must hold its request until the acknowledge.
   wire vga_take;
   wire mem_done;

   assign vga_take = (state_q == ST_IDLE) && i_vga_req && !o_vga_ack;
   assign mem_done = (state_q == ST_MEM) && i_mem_ack;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q        <= ST_IDLE;
         o_mem_req      <= 1'b0;
         o_mem_we       <= 1'b0;
         o_mem_addr     <= 20'h00000;
         o_mem_plane_en <= 4'h0;
         o_mem_wdata    <= 32'h00000000;
         rd_plane_q     <= 2'b00;
         rd_is_read_q   <= 1'b0;
         o_vga_ack      <= 1'b0;
         o_vga_rdata    <= 8'h00;
      end else begin
         o_vga_ack <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (vga_take) begin
                  state_q        <= ST_MEM;
                  o_mem_req      <= 1'b1;
                  o_mem_we       <= i_vga_we;
                  o_mem_addr     <= mem_addr_d;
                  o_mem_plane_en <= i_vga_we ? wr_planes_d : 4'hf;
                  o_mem_wdata    <= plane_data;
                  rd_plane_q     <= rd_plane_d;
                  rd_is_read_q   <= !i_vga_we;
               end
            end
            ST_MEM: begin
               if (i_mem_ack) begin
                  state_q   <= ST_IDLE;
                  o_mem_req <= 1'b0;
                  o_vga_ack <= 1'b1;
                  if (rd_is_read_q) begin
                     o_vga_rdata <= read_mode_select ? cmp_byte
                                                     : plane_byte;
                  end
               end
            end
            default: begin
               state_q   <= ST_IDLE;
               o_mem_req <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   // A frame buffer read returning in the same cycle as a register write to
   // the latch wins, so the latch takes that read's data and the register write is lost.
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         write_ctrl_q  <= `WRITE_CTRL_RESET;
         read_ctrl_q   <= `READ_CTRL_RESET;
         base_offset_q <= `BASE_OFFSET_RESET;
         latch_q       <= `LATCH_RESET;
         o_reg_ack     <= 1'b0;
         o_reg_rdata   <= 32'h00000000;
      end else begin
         o_reg_ack <= reg_hit;
         if (reg_hit && !i_reg_we) begin
            o_reg_rdata <= reg_value(i_reg_addr);
         end
         if (reg_wr && i_reg_addr == `OFS_WRITE_CTRL) begin
            write_ctrl_q <= i_reg_wdata & `WRITE_CTRL_MASK;
         end
         if (reg_wr && i_reg_addr == `OFS_READ_CTRL) begin
            read_ctrl_q <= i_reg_wdata & `READ_CTRL_MASK;
         end
         if (reg_wr && i_reg_addr == `OFS_BASE_OFFSET) begin
            base_offset_q <= i_reg_wdata & `BASE_OFFSET_MASK;
         end
         if (mem_done && rd_is_read_q) begin
            latch_q <= i_mem_rdata;
         end else if (reg_wr && i_reg_addr == `OFS_LATCH) begin
            latch_q <= i_reg_wdata;
         end
      end
   end

endmodule // vga_planar_memory_path

// [mem_path_checker.sv]
`timescale 1ns/100ps
`include "vga_path_consts.vh"

module mem_path_checker (
   // Clock and reset
   input wire        i_clk,
   input wire        i_nrst,
   // Register access
   input wire        i_reg_req,
   input wire        i_reg_we,
   input wire [15:0] i_reg_addr,
   input wire [31:0] o_reg_rdata,
   input wire        o_reg_ack,
   // Processor and memory side
   input wire        i_vga_req,
   input wire        i_vga_we,
   input wire        o_vga_ack,
   input wire        o_mem_req,
   input wire        o_mem_we,
   input wire [19:0] o_mem_addr,
   input wire [3:0]  o_mem_plane_en,
   input wire        i_mem_ack
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   wire in_win = (i_reg_addr >= `WIN_BASE) && (i_reg_addr < `WIN_BASE + `WIN_SIZE);

   reg_ack_a: assert property (i_reg_req && in_win |=> o_reg_ack)
      else $error("register access in window not acknowledged");
   reg_refuse_a: assert property (!(i_reg_req && in_win) |=> !o_reg_ack)
      else $error("acknowledge without a request in window");
   rdata_hold_a: assert property (!(i_reg_req && !i_reg_we) |=> $stable(o_reg_rdata))
      else $error("register read data changed without a read");
   mem_take_a: assert property ($rose(o_mem_req) |-> $past(i_vga_req)
                                && o_mem_we == $past(i_vga_we))
      else $error("memory request not caused by a processor request");
   mem_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
                                && $stable(o_mem_addr) && $stable(o_mem_plane_en))
      else $error("memory request changed before acknowledge");
   vga_done_a: assert property (o_mem_req && i_mem_ack |=> o_vga_ack && !o_mem_req)
      else $error("processor acknowledge missing after memory acknowledge");
   vga_pulse_a: assert property (o_vga_ack |-> $past(i_mem_ack) ##1 !o_vga_ack)
      else $error("processor acknowledge without cause or too long");
   read_planes_a: assert property (o_mem_req && !o_mem_we |-> o_mem_plane_en == 4'hf)
      else $error("memory read does not fetch all planes");

   cover property (o_reg_ack);
   cover property ($rose(o_mem_req) && o_mem_we);
   cover property (o_vga_ack && !i_vga_we);
endmodule // mem_path_checker

bind vga_planar_memory_path mem_path_checker u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_req(i_reg_req), .i_reg_we(i_reg_we),
   .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
   .i_vga_req(i_vga_req), .i_vga_we(i_vga_we), .o_vga_ack(o_vga_ack),
   .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
   .o_mem_plane_en(o_mem_plane_en), .i_mem_ack(i_mem_ack)
);

// [mem_model.sv]
`timescale 1ns/100ps

module mem_model (
   // Clock and pacing
   input  wire        i_clk,
   input  wire [3:0]  i_wait,
   // Request
   input  wire        i_req,
   input  wire        i_we,
   input  wire [19:0] i_addr,
   input  wire [3:0]  i_plane_en,
   input  wire [31:0] i_wdata,
   // Response and last access
   output reg  [31:0] o_rdata,
   output reg         o_ack,
   output reg  [19:0] o_last_addr,
   output reg  [3:0]  o_last_en,
   output reg  [31:0] o_last_wdata
);
   reg [3:0] cnt_q;

   initial begin
      o_rdata = 32'h0;
      o_ack = 1'b0;
      cnt_q = 4'h0;
   end

   // Idle read data flips every cycle, so a sample taken the cycle after the acknowledge reads the inverted data.
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (cnt_q == i_wait) begin
            cnt_q <= 4'h0;
            o_ack <= 1'b1;
            o_last_addr <= i_addr;
            o_last_en <= i_plane_en;
            o_last_wdata <= i_wdata;
            if (!i_we) begin
               o_rdata <= {i_addr[7:0], ~i_addr[7:0], i_addr[7:0] ^ 8'h5a, 8'hc3};
            end
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule // mem_model

// [tb_top.sv]
`timescale 1ns/100ps
`include "vga_path_consts.vh"

module tb_top;
   logic        i_clk, i_nrst, i_reg_req, i_reg_we, i_vga_req, i_vga_we;
   logic [15:0] i_reg_addr, i_vga_addr;
   logic [31:0] i_reg_wdata, q, lat;
   logic [7:0]  i_vga_wdata;
   logic [3:0]  mem_wait;
   logic        ak;
   wire  [31:0] o_reg_rdata, o_mem_wdata, i_mem_rdata, m_wdata;
   wire  [19:0] o_mem_addr, m_addr;
   wire  [7:0]  o_vga_rdata;
   wire  [3:0]  o_mem_plane_en, m_en;
   wire         o_reg_ack, o_vga_ack, o_mem_req, o_mem_we, i_mem_ack;
   int          err_total, checks, cycles;

   vga_planar_memory_path dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_req(i_reg_req), .i_reg_we(i_reg_we),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_ack(o_reg_ack), .i_vga_req(i_vga_req), .i_vga_we(i_vga_we),
      .i_vga_addr(i_vga_addr), .i_vga_wdata(i_vga_wdata), .o_vga_rdata(o_vga_rdata),
      .o_vga_ack(o_vga_ack), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
      .o_mem_addr(o_mem_addr), .o_mem_plane_en(o_mem_plane_en), .o_mem_wdata(o_mem_wdata),
      .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack));

   mem_model u_mem (
      .i_clk(i_clk), .i_wait(mem_wait), .i_req(o_mem_req), .i_we(o_mem_we),
      .i_addr(o_mem_addr), .i_plane_en(o_mem_plane_en), .i_wdata(o_mem_wdata),
      .o_rdata(i_mem_rdata), .o_ack(i_mem_ack), .o_last_addr(m_addr),
      .o_last_en(m_en), .o_last_wdata(m_wdata));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Requests are held for one edge, then a free cycle follows before the next one.
   task automatic reg_acc(input logic we, input logic [15:0] a, input logic [31:0] d);
      i_reg_req = 1'b1;
      i_reg_we = we;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(posedge i_clk);
      #1;
      i_reg_req = 1'b0;
      ak = o_reg_ack;
      q = o_reg_rdata;
      @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_acc(1'b1, a, d);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      reg_acc(1'b0, a, 32'h0);
      chk({31'h0, ak}, 32'h1);
      chk(q, exp);
   endtask

   task automatic vga_acc(input logic we, input logic [15:0] a);
      int n;
      n = 0;
      i_vga_req = 1'b1;
      i_vga_we = we;
      i_vga_addr = a;
      i_vga_wdata = 8'h96;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (o_vga_ack !== 1'b1 && n < 40);
      i_vga_req = 1'b0;
      chk({31'h0, o_vga_ack}, 32'h1);
      q = {24'h0, o_vga_rdata};
      @(posedge i_clk);
      #1;
   endtask

   function automatic logic [31:0] exp_w(input logic [31:0] c, l, input logic [7:0] b);
      logic [7:0] r, m, v;
      r = 8'({b, b} >> c[18:16]);
      m = c[20] ? (c[7:0] & r) : c[7:0];
      for (int p = 0; p < 4; p++) begin
         v = c[20] ? {8{c[8+p]}} : c[19] ? {8{b[p]}} : c[12+p] ? {8{c[8+p]}} : r;
         exp_w[8*p +: 8] = (v & m) | (l[8*p +: 8] & ~m);
      end
   endfunction

   function automatic logic [7:0] exp_c(input logic [31:0] rc, d);
      for (int b = 0; b < 8; b++) begin
         exp_c[b] = ~|(rc[7:4] & ({d[24+b], d[16+b], d[8+b], d[b]} ^ rc[3:0]));
      end
   endfunction

   task automatic wr_case(input logic [31:0] c, rc, input logic [15:0] a,
                          input logic [19:0] ea, input logic [3:0] en);
      wr(`OFS_WRITE_CTRL, c);
      wr(`OFS_READ_CTRL, rc);
      vga_acc(1'b1, a);
      chk(32'(m_addr), 32'(ea));
      chk(32'(m_en), 32'(en));
      chk(m_wdata, exp_w(c, lat, 8'h96));
   endtask

   task automatic rd_case(input logic [31:0] rc, input logic [15:0] a,
                          input logic [19:0] ea, input logic [1:0] pl);
      logic [31:0] d;
      d = {ea[7:0], ~ea[7:0], ea[7:0] ^ 8'h5a, 8'hc3};
      wr(`OFS_READ_CTRL, rc);
      vga_acc(1'b0, a);
      chk(32'(m_addr), 32'(ea));
      chk(q, rc[8] ? 32'(exp_c(rc, d)) : 32'(d[8*pl +: 8]));
      rd(`OFS_LATCH, d);
   endtask

   initial begin
      {i_nrst, i_reg_req, i_reg_we, i_vga_req, i_vga_we} = 5'h0;
      i_reg_addr = 16'h0;
      i_vga_addr = 16'h0;
      i_reg_wdata = 32'h0;
      i_vga_wdata = 8'h0;
      mem_wait = 4'h0;
      lat = 32'h0ff033cc;
      repeat (2) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      rd(`OFS_WRITE_CTRL, 32'h0);
      rd(`OFS_READ_CTRL, 32'h0);
      rd(`OFS_BASE_OFFSET, 32'h0);
      rd(`OFS_LATCH, 32'h0);
      rd(16'h8100, 32'h0);
      reg_acc(1'b1, 16'h8300, 32'h1);
      chk({31'h0, ak}, 32'h0);
      wr(`OFS_WRITE_CTRL, 32'hffffffff);
      rd(`OFS_WRITE_CTRL, `WRITE_CTRL_MASK);
      wr(`OFS_READ_CTRL, 32'hffffffff);
      rd(`OFS_READ_CTRL, `READ_CTRL_MASK);
      wr(`OFS_BASE_OFFSET, 32'hffffffff);
      rd(`OFS_BASE_OFFSET, `BASE_OFFSET_MASK);
      wr(`OFS_LATCH, lat);
      rd(`OFS_LATCH, lat);
      wr(`OFS_BASE_OFFSET, 32'h00000205);
      wr_case(32'h0b0353a5, 32'h0, 16'h1234, 20'h15234, 4'hb);
      wr_case(32'h0f08003c, 32'h0, 16'h1234, 20'h15234, 4'hf);
      wr_case(32'h0f15063f, 32'h0, 16'h1234, 20'h15234, 4'hf);
      wr_case(32'h0b0353a5, 32'h6000, 16'h000f, 20'h14003, 4'h8);
      wr_case(32'h0b0353a5, 32'h0400, 16'h0011, 20'h14011, 4'ha);
      wr_case(32'h0b0353a5, 32'h2400, 16'h0011, 20'h14011, 4'h2);
      mem_wait = 4'h3;
      rd_case(32'h00020000, 16'h0021, 20'h08021, 2'd2);
      rd_case(32'h00019800, 16'h8006, 20'h08007, 2'd1);
      rd_case(32'h00020200, 16'h0031, 20'h08031, 2'd3);
      rd_case(32'h00002000, 16'h0032, 20'h08032, 2'd2);
      rd_case(32'h00000164, 16'h0040, 20'h08040, 2'd0);
      complete_run();
   end
endmodule // tb_top
